// ===== sfa_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************
// Behavioural serial flash on the shared link
// ********************************************
module sfa_flash_model (
   // Link from the block
   input wire logic sclk_in,
   input wire logic sel0_n_in,
   input wire logic sel1_n_in,
   input wire logic [7:0] dq_in,
   input wire logic [1:0] width_in,
   // Data back to the block
   output logic [7:0] dq_out
);
   logic [63:0] sr;
   logic [31:0] rd;
   logic [31:0] data;
   logic [23:0] addr;
   logic [7:0] cmd;
   logic sel1;
   int bits;
   int frames;
   int ln;
   wire active = !(sel0_n_in && sel1_n_in);
   assign ln = 1 << width_in;
   initial begin
      dq_out = 8'h00;
      bits = 0;
      frames = 0;
      sr = 64'h0;
      cmd = 8'h00;
   end
   always @(negedge sel0_n_in or negedge sel1_n_in) begin
      bits = 0;
      sel1 = !sel1_n_in;
   end
   // Bits are taken on rising clock edges in either clock mode, top lane first.
   always @(posedge sclk_in) begin
      if (active) begin
         for (int i = ln - 1; i >= 0; i--) sr = {sr[62:0], dq_in[i]};
         bits += ln;
         if (bits == 32) {cmd, addr} = sr[31:0];
         if (bits == 64) data = sr[31:0];
      end
   end
   // Read data changes on falling edges so it is steady at the sampling edge.
   always @(negedge sclk_in) begin
      if (active && bits >= 32 && cmd == sfa_pkg::CMD_READ) begin
         if (bits == 32) rd = {8'h5a, addr};
         dq_out = ~dq_out;
         for (int i = ln - 1; i >= 0; i--) begin
            dq_out[i] = rd[31];
            rd = rd << 1;
         end
      end
   end
   // A released bus shows the inverse of its last level, never a stale value.
   always @(posedge sel0_n_in or posedge sel1_n_in) begin
      if (!active) begin
         frames++;
         dq_out = ~dq_out;
      end
   end
endmodule
`default_nettype wire

// ===== sfa_link_engine.sv
`timescale 1ns/1ns
`default_nettype none
module sfa_link_engine (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Transaction side
   sfa_link_if.eng lk,
   // Flash pins
   input wire logic [7:0] dq_in,
   output logic sclk_out,
   output logic sel0_n_out,
   output logic sel1_n_out,
   output logic [7:0] dq_out,
   output logic [7:0] dq_oe_n_out
);
   sfa_pkg::sfa_lk_t st_r;
   logic [2:0] div_r;
   logic phase_r;
   logic [63:0] sh_r;
   logic [31:0] rx_r;
   logic [6:0] beats_r;
   logic [6:0] out_r;
   logic [2:0] gap_r;
   logic [1:0] width_r;
   logic mode3_r;
   logic done_r;
   logic [7:0] dq_nxt_w;

   // ************************************************
   // Decode
   // ************************************************
   wire [3:0] lanes_w = 4'h1 << width_r;
   wire [7:0] mask_w = 8'((9'h001 << lanes_w) - 9'h001);
   wire tick_w = (div_r == 3'(sfa_pkg::SCK_HALF_CYC - 1));
   wire last_w = (beats_r == 7'h01);
   wire is_rd_w = (lk.op == sfa_pkg::OP_READ);
   wire [7:0] cmd_w = is_rd_w ? sfa_pkg::CMD_READ :
      (lk.op == sfa_pkg::OP_PROG) ? sfa_pkg::CMD_PROG :
      (lk.op == sfa_pkg::OP_ERASE) ? sfa_pkg::CMD_ERASE : sfa_pkg::CMD_CONFIG;
   wire [31:0] tail_w = (lk.op == sfa_pkg::OP_PROG) ? lk.wdata : 32'h0;
   wire [63:0] frame_w = (lk.op == sfa_pkg::OP_CONFIG) ?
      {cmd_w, lk.wdata, 24'h0} : {cmd_w, lk.addr, tail_w};
   wire [6:0] obits_w = (lk.op == sfa_pkg::OP_PROG) ? sfa_pkg::BITS_FULL :
      (lk.op == sfa_pkg::OP_CONFIG) ? sfa_pkg::BITS_CMD_DATA : sfa_pkg::BITS_CMD_ADDR;
   wire [6:0] bits_w = obits_w + (is_rd_w ? sfa_pkg::BITS_RDATA : 7'h00);

   // Most significant bit leaves on the highest active lane.
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_lane
         assign dq_nxt_w[i] = mask_w[i] & sh_r[6'(7'd64 + 7'(i) - 7'(lanes_w))];
      end
   endgenerate

   assign lk.busy = (st_r != sfa_pkg::SFA_LK_IDLE);
   assign lk.done = done_r;
   assign lk.rdata = rx_r;

   // ************************************************
   // Sequencer
   // ************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_r <= sfa_pkg::SFA_LK_IDLE;
         div_r <= 3'h0;
         phase_r <= 1'b0;
         sh_r <= 64'h0;
         rx_r <= 32'h0;
         beats_r <= 7'h0;
         out_r <= 7'h0;
         gap_r <= 3'h0;
         width_r <= 2'h0;
         mode3_r <= 1'b0;
         done_r <= 1'b0;
         sclk_out <= 1'b0;
         sel0_n_out <= 1'b1;
         sel1_n_out <= 1'b1;
         dq_out <= 8'h0;
         dq_oe_n_out <= sfa_pkg::OE_N_IDLE;
      end else begin
         done_r <= 1'b0;
         unique case (st_r)
            sfa_pkg::SFA_LK_IDLE: if (lk.start) begin
               sh_r <= frame_w;
               rx_r <= 32'h0;
               width_r <= lk.width;
               mode3_r <= lk.mode3;
               beats_r <= bits_w >> lk.width;
               out_r <= obits_w >> lk.width;
               div_r <= 3'h0;
               phase_r <= 1'b0;
               sclk_out <= 1'b0;
               sel0_n_out <= lk.cs1;
               sel1_n_out <= ~lk.cs1;
               st_r <= sfa_pkg::SFA_LK_SHIFT;
            end
            sfa_pkg::SFA_LK_SHIFT: begin
               dq_out <= dq_nxt_w;
               dq_oe_n_out <= (out_r != 7'h0) ? ~mask_w : sfa_pkg::OE_N_IDLE;
               div_r <= tick_w ? 3'h0 : div_r + 3'h1;
               if (tick_w) begin
                  phase_r <= ~phase_r;
                  sclk_out <= ~phase_r;
                  if (!phase_r) begin
                     if (out_r == 7'h0) begin
                        rx_r <= (rx_r << lanes_w) | {24'h0, dq_in & mask_w};
                     end
                  end else begin
                     sh_r <= sh_r << lanes_w;
                     beats_r <= beats_r - 7'h01;
                     if (out_r != 7'h0) begin
                        out_r <= out_r - 7'h01;
                     end
                     if (last_w) begin
                        st_r <= sfa_pkg::SFA_LK_GAP;
                        gap_r <= 3'h0;
                        sel0_n_out <= 1'b1;
                        sel1_n_out <= 1'b1;
                        sclk_out <= mode3_r;
                        dq_oe_n_out <= sfa_pkg::OE_N_IDLE;
                     end
                  end
               end
            end
            sfa_pkg::SFA_LK_GAP: begin
               gap_r <= gap_r + 3'h1;
               if (gap_r == 3'(sfa_pkg::CS_HIGH_CYC - 1)) begin
                  st_r <= sfa_pkg::SFA_LK_IDLE;
                  done_r <= 1'b1;
               end
            end
         endcase
      end
   end

   a_one_select: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (sel0_n_out | sel1_n_out)) else $error("both flash selects low");
   a_idle_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_r == sfa_pkg::SFA_LK_IDLE) |-> (sclk_out == mode3_r))
      else $error("serial clock not at idle level");
   a_lane_unused: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_r == sfa_pkg::SFA_LK_SHIFT) |-> ((~dq_oe_n_out & ~mask_w) == 8'h0))
      else $error("unused lane driven");
   a_gap_length: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ($past(st_r) == sfa_pkg::SFA_LK_SHIFT && st_r == sfa_pkg::SFA_LK_GAP) |->
      (st_r == sfa_pkg::SFA_LK_GAP)[*5] ##1 (st_r == sfa_pkg::SFA_LK_IDLE && done_r))
      else $error("select high time wrong");
endmodule
`default_nettype wire

// ===== sfa_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfa_link_if;
   logic start;
   logic [1:0] op;
   logic cs1;
   logic [23:0] addr;
   logic [31:0] wdata;
   logic [1:0] width;
   logic mode3;
   logic busy;
   logic done;
   logic [31:0] rdata;
   modport arb (output start, op, cs1, addr, wdata, width, mode3, input busy, done, rdata);
   modport eng (input start, op, cs1, addr, wdata, width, mode3, output busy, done, rdata);
endinterface
`default_nettype wire

// ===== sfa_pkg.sv
package sfa_pkg;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCK_HALF_NS = 16;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_HIGH_NS = 40;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ************************************************
   // Frame layout
   // ************************************************
   localparam logic [6:0] BITS_CMD_ADDR = 7'h20;
   localparam logic [6:0] BITS_CMD_DATA = 7'h28;
   localparam logic [6:0] BITS_FULL = 7'h40;
   localparam logic [6:0] BITS_RDATA = 7'h20;
   localparam logic [7:0] OE_N_IDLE = 8'hff;
   // ************************************************
   // Operations and commands
   // ************************************************
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROG = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] OP_CONFIG = 2'h3;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_PROG = 8'h02;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CONFIG = 8'h01;
   localparam logic PROC_APP = 1'b1;
   typedef enum logic [1:0] {
      SFA_ARB_IDLE = 2'h0,
      SFA_ARB_RUN = 2'h1,
      SFA_ARB_RESP = 2'h3
   } sfa_arb_t;
   typedef enum logic [1:0] {
      SFA_LK_IDLE = 2'h0,
      SFA_LK_SHIFT = 2'h1,
      SFA_LK_GAP = 2'h3
   } sfa_lk_t;
endpackage

// ===== sfa_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Link uses 1, 2, 4 or 8 data lanes at single data rate.
// - Fetched instruction words are decrypted before reaching the instruction cache.
// - Fetches use the direct path; data transfers use the indirect path.
// - With hardware control on, direct and indirect paths run concurrently.
// - Each processor has separate direct and indirect subordinate ports.
// - Hardware arbitrates between both processors' controllers without software.
// - Both controllers are multiplexed onto the one shared serial link.
// - The shared flash is split into two regions, one per processor.
// - Only two arrangements exist: shared flash or one flash per processor.
// - In shared mode only the network processor configures, programs, erases.
// - In shared mode the application processor may only fetch directly.
// - In shared mode the application processor reads only its own region.
// - In shared mode the network processor reaches the whole flash.
// - After reset code is fetched from flash and executed in place.
// - Protected code in flash cannot be programmed or erased.
// - In separate mode the application processor fully owns its flash.
// - Link runs in clock mode 0 or mode 3.
module sfa_top (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Arrangement and policy
   input wire logic shared_mode_in,
   input wire logic hw_ctrl_en_in,
   input wire logic wp_en_in,
   input wire logic [23:0] region_split_in,
   input wire logic [23:0] code_limit_in,
   input wire logic [1:0] width_in,
   input wire logic mode3_in,
   // Direct fetch ports, index 0 network, 1 application
   input wire logic [1:0] dir_req_in,
   input wire logic [1:0][23:0] dir_addr_in,
   input wire logic [1:0] dec_en_in,
   input wire logic [1:0][31:0] keystream_in,
   output logic [1:0] dir_ready_out,
   output logic [1:0] dir_err_out,
   output logic [1:0][31:0] dir_rdata_out,
   // Indirect data ports
   input wire logic [1:0] ind_req_in,
   input wire logic [1:0][1:0] ind_op_in,
   input wire logic [1:0][23:0] ind_addr_in,
   input wire logic [1:0][31:0] ind_wdata_in,
   output logic [1:0] ind_ready_out,
   output logic [1:0] ind_err_out,
   output logic [1:0][31:0] ind_rdata_out,
   // Flash pins
   input wire logic [7:0] dq_in,
   output logic sclk_out,
   output logic flash_select_0_n_out,
   output logic flash_select_1_n_out,
   output logic [7:0] dq_out,
   output logic [7:0] dq_oe_n_out
);
   sfa_pkg::sfa_arb_t st_r;
   logic [1:0] last_r;
   logic [1:0] cur_r;
   logic start_r;
   logic err_r;
   logic [1:0] op_r;
   logic [23:0] addr_r;
   logic [31:0] wdata_r;
   logic cs1_r;
   logic [1:0] sel_w;
   logic [3:0] pend_w;

   sfa_link_if lk_i ();

   // ************************************************
   // Request decode
   // ************************************************
   // Without hardware control a controller's indirect job holds off its fetches.
   assign pend_w = {ind_req_in, dir_req_in & ({2{hw_ctrl_en_in}} | ~ind_req_in)};
   wire any_w = |pend_w;
   wire sel_proc_w = sel_w[0];
   wire sel_ind_w = sel_w[1];
   wire [23:0] sel_addr_w = sel_ind_w ? ind_addr_in[sel_proc_w] : dir_addr_in[sel_proc_w];
   wire [1:0] sel_op_w = sel_ind_w ? ind_op_in[sel_proc_w] : sfa_pkg::OP_READ;
   wire app_w = (sel_proc_w == sfa_pkg::PROC_APP);
   wire out_region_w = (sel_addr_w >= region_split_in);
   wire deny_share_w = shared_mode_in & app_w & (sel_ind_w | out_region_w);
   wire is_mod_w = (sel_op_w == sfa_pkg::OP_PROG) | (sel_op_w == sfa_pkg::OP_ERASE);
   wire deny_wp_w = wp_en_in & is_mod_w & (sel_addr_w < code_limit_in);
   wire deny_w = deny_share_w | deny_wp_w;
   // Shared mode keeps everything on select 0 unless hardware control splits paths.
   wire cs1_w = shared_mode_in ? (hw_ctrl_en_in & sel_ind_w) : app_w;
   wire cur_proc_w = cur_r[0];
   wire [31:0] key_w = dec_en_in[cur_proc_w] ? keystream_in[cur_proc_w] : 32'h0;
   wire [31:0] dec_word_w = lk_i.rdata ^ key_w;

   assign lk_i.start = start_r;
   assign lk_i.op = op_r;
   assign lk_i.cs1 = cs1_r;
   assign lk_i.addr = addr_r;
   assign lk_i.wdata = wdata_r;
   assign lk_i.width = width_in;
   assign lk_i.mode3 = mode3_in;

   // ************************************************
   // Round robin pick
   // ************************************************
   always_comb begin
      logic [1:0] idx;
      logic found;
      idx = 2'h0;
      found = 1'b0;
      sel_w = last_r;
      for (int k = 1; k <= 4; k++) begin
         idx = last_r + 2'(k);
         if (!found && pend_w[idx]) begin
            sel_w = idx;
            found = 1'b1;
         end
      end
   end

   // ************************************************
   // Arbiter
   // ************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_r <= sfa_pkg::SFA_ARB_IDLE;
         last_r <= 2'h3;
         cur_r <= 2'h0;
         start_r <= 1'b0;
         err_r <= 1'b0;
         op_r <= sfa_pkg::OP_READ;
         addr_r <= 24'h0;
         wdata_r <= 32'h0;
         cs1_r <= 1'b0;
         dir_ready_out <= 2'h0;
         dir_err_out <= 2'h0;
         dir_rdata_out <= '0;
         ind_ready_out <= 2'h0;
         ind_err_out <= 2'h0;
         ind_rdata_out <= '0;
      end else begin
         start_r <= 1'b0;
         dir_ready_out <= 2'h0;
         dir_err_out <= 2'h0;
         ind_ready_out <= 2'h0;
         ind_err_out <= 2'h0;
         unique case (st_r)
            sfa_pkg::SFA_ARB_IDLE: if (any_w && !lk_i.busy) begin
               cur_r <= sel_w;
               last_r <= sel_w;
               op_r <= sel_op_w;
               addr_r <= sel_addr_w;
               wdata_r <= ind_wdata_in[sel_proc_w];
               cs1_r <= cs1_w;
               err_r <= deny_w;
               if (deny_w) begin
                  st_r <= sfa_pkg::SFA_ARB_RESP;
                  if (sel_ind_w) begin
                     ind_err_out[sel_proc_w] <= 1'b1;
                  end else begin
                     dir_err_out[sel_proc_w] <= 1'b1;
                  end
               end else begin
                  start_r <= 1'b1;
                  st_r <= sfa_pkg::SFA_ARB_RUN;
               end
            end
            sfa_pkg::SFA_ARB_RUN: if (lk_i.done) begin
               st_r <= sfa_pkg::SFA_ARB_RESP;
               if (cur_r[1]) begin
                  ind_ready_out[cur_proc_w] <= 1'b1;
                  ind_rdata_out[cur_proc_w] <= lk_i.rdata;
               end else begin
                  dir_ready_out[cur_proc_w] <= 1'b1;
                  dir_rdata_out[cur_proc_w] <= dec_word_w;
               end
            end
            sfa_pkg::SFA_ARB_RESP: st_r <= sfa_pkg::SFA_ARB_IDLE;
         endcase
      end
   end

   // ************************************************
   // Shared link
   // ************************************************
   sfa_link_engine sfa_link_engine_i (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .lk(lk_i.eng),
      .dq_in(dq_in),
      .sclk_out(sclk_out),
      .sel0_n_out(flash_select_0_n_out),
      .sel1_n_out(flash_select_1_n_out),
      .dq_out(dq_out),
      .dq_oe_n_out(dq_oe_n_out)
   );

   wire idle_pick_w = (st_r == sfa_pkg::SFA_ARB_IDLE) && any_w && !lk_i.busy;

   a_app_fetch_only: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (idle_pick_w && shared_mode_in && sel_w == 2'h3) |=>
      (st_r == sfa_pkg::SFA_ARB_RESP && err_r && ind_err_out[1]))
      else $error("application indirect access not refused");
   a_app_region: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (idle_pick_w && shared_mode_in && sel_w == 2'h1 && out_region_w) |=>
      dir_err_out[1] ##1 (st_r == sfa_pkg::SFA_ARB_IDLE))
      else $error("application read outside region not refused");
   a_net_open: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (idle_pick_w && !sel_proc_w && !deny_wp_w) |=> start_r)
      else $error("network access not started");
   a_deny_nolink: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (idle_pick_w && deny_w) |=> (!start_r)[*2])
      else $error("refused access reached the link");
   a_rr_alternate: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (idle_pick_w && pend_w[0] && pend_w[1] && last_r == 2'h0) |-> (sel_w == 2'h1))
      else $error("arbiter did not alternate");
   a_grant_gap: assert property (@(posedge core_clk_in) disable iff (rst_in)
      start_r |-> !lk_i.busy)
      else $error("grant during a frame");
   a_fetch_decrypt: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_r == sfa_pkg::SFA_ARB_RUN && lk_i.done && !cur_r[1]) |=>
      (dir_rdata_out[$past(cur_proc_w)] == $past(dec_word_w)))
      else $error("fetched word not decrypted");
endmodule
`default_nettype wire

// ===== shared_serial_flash_access_tb.sv
`timescale 1ns/1ns
`default_nettype none
module shared_serial_flash_access_tb;
   logic clk, rst, shared, hwc, wp, mode3, sclk, s0n, s1n;
   logic [23:0] split, limit;
   logic [1:0] width, dir_req, dec_en, dir_rdy, dir_err, ind_req, ind_rdy, ind_err;
   logic [1:0][23:0] dir_addr, ind_addr;
   logic [1:0][31:0] key, dir_rd, ind_wd, ind_rd;
   logic [1:0][1:0] ind_op;
   logic [7:0] dq_to, dq_from, oen;
   logic got_rdy, got_err;
   logic [31:0] got_rd;
   int errors, samples_checked;
   always #4 clk = ~clk;
   sfa_top sfa_top_i (.core_clk_in(clk), .rst_in(rst), .shared_mode_in(shared),
      .hw_ctrl_en_in(hwc), .wp_en_in(wp), .region_split_in(split), .code_limit_in(limit),
      .width_in(width), .mode3_in(mode3), .dir_req_in(dir_req), .dir_addr_in(dir_addr),
      .dec_en_in(dec_en), .keystream_in(key), .dir_ready_out(dir_rdy), .dir_err_out(dir_err),
      .dir_rdata_out(dir_rd), .ind_req_in(ind_req), .ind_op_in(ind_op),
      .ind_addr_in(ind_addr), .ind_wdata_in(ind_wd), .ind_ready_out(ind_rdy),
      .ind_err_out(ind_err), .ind_rdata_out(ind_rd), .dq_in(dq_to), .sclk_out(sclk),
      .flash_select_0_n_out(s0n), .flash_select_1_n_out(s1n), .dq_out(dq_from),
      .dq_oe_n_out(oen));
   sfa_flash_model sfa_flash_model_i (.sclk_in(sclk), .sel0_n_in(s0n), .sel1_n_in(s1n),
      .dq_in(dq_from), .width_in(width), .dq_out(dq_to));
   task automatic final_report;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One request held until its answer pulse, then dropped at the closing edge.
   task automatic xfer(input bit ind, input int p, input logic [1:0] op, input logic [23:0] a,
      input logic [31:0] wd);
      int n;
      @(posedge clk);
      if (ind) begin
         ind_req[p] <= 1'b1;
         ind_op[p] <= op;
         ind_addr[p] <= a;
         ind_wd[p] <= wd;
      end else begin
         dir_req[p] <= 1'b1;
         dir_addr[p] <= a;
      end
      got_rdy = 1'b0;
      got_err = 1'b0;
      for (n = 0; n < 2000 && got_rdy !== 1'b1 && got_err !== 1'b1; n++) begin
         @(posedge clk);
         got_rdy = ind ? ind_rdy[p] : dir_rdy[p];
         got_err = ind ? ind_err[p] : dir_err[p];
         got_rd = ind ? ind_rd[p] : dir_rd[p];
      end
      ind_req[p] <= 1'b0;
      dir_req[p] <= 1'b0;
      if (n == 2000) begin
         errors++;
         final_report;
      end
   endtask
   task automatic t_reset;
      check("idle pins", {s0n, s1n, sclk, oen, dq_from}, {3'b110, 8'hff, 8'h00});
   endtask
   task automatic t_widths;
      for (int w = 0; w < 4; w++) begin
         width <= w[1:0];
         mode3 <= w[0];
         xfer(1'b0, 0, sfa_pkg::OP_READ, 24'h000100 + 24'(w), 32'h0);
         check("fetch ok", got_rdy, 1'b1);
         check("fetch data", got_rd, {8'h5a, 24'h000100 + 24'(w)});
         check("sclk idle", sclk, w[0]);
         check("select", sfa_flash_model_i.sel1, 1'b0);
      end
      width <= 2'h0;
      mode3 <= 1'b0;
   endtask
   task automatic t_decrypt;
      dec_en <= 2'b01;
      key[0] <= 32'h3c96_a50f;
      xfer(1'b0, 0, sfa_pkg::OP_READ, 24'h000400, 32'h0);
      check("decrypted", got_rd, 32'h5a00_0400 ^ 32'h3c96_a50f);
      dec_en <= 2'b00;
   endtask
   task automatic t_shared_app;
      int f;
      shared <= 1'b1;
      split <= 24'h008000;
      xfer(1'b0, 1, sfa_pkg::OP_READ, 24'h007ffc, 32'h0);
      check("app own region", got_rd, 32'h5a00_7ffc);
      f = sfa_flash_model_i.frames;
      xfer(1'b0, 1, sfa_pkg::OP_READ, 24'h008000, 32'h0);
      check("app other region", {got_rdy, got_err}, 2'b01);
      for (int op = 0; op < 4; op++) begin
         xfer(1'b1, 1, op[1:0], 24'h000010, 32'h1);
         check("app indirect", {got_rdy, got_err}, 2'b01);
      end
      check("no refused frames", sfa_flash_model_i.frames, f);
   endtask
   task automatic t_net_ops;
      logic [7:0] cmds [4] = '{sfa_pkg::CMD_READ, sfa_pkg::CMD_PROG, sfa_pkg::CMD_ERASE,
         sfa_pkg::CMD_CONFIG};
      hwc <= 1'b1;
      for (int op = 0; op < 4; op++) begin
         xfer(1'b1, 0, op[1:0], 24'hf00020, 32'hc001_d00d);
         check("net op ok", got_rdy, 1'b1);
         check("command", sfa_flash_model_i.cmd, cmds[op]);
         if (op < 3) check("address", sfa_flash_model_i.addr, 24'hf00020);
         if (op == 0) check("net read data", got_rd, 32'h5af0_0020);
         if (op == 1) check("prog data", sfa_flash_model_i.data, 32'hc001_d00d);
         check("indirect select", sfa_flash_model_i.sel1, 1'b1);
      end
      hwc <= 1'b0;
   endtask
   task automatic t_protect;
      wp <= 1'b1;
      limit <= 24'h001000;
      xfer(1'b1, 0, sfa_pkg::OP_PROG, 24'h000fff, 32'h0);
      check("protected prog", {got_rdy, got_err}, 2'b01);
      xfer(1'b1, 0, sfa_pkg::OP_ERASE, 24'h001000, 32'h0);
      check("unprotected erase", {got_rdy, got_err}, 2'b10);
      check("direct data held", dir_rd[0], 32'h5a00_0400 ^ 32'h3c96_a50f);
      wp <= 1'b0;
   endtask
   task automatic t_separate_app;
      shared <= 1'b0;
      xfer(1'b1, 1, sfa_pkg::OP_PROG, 24'h00fff0, 32'h1234_5678);
      check("app prog", got_rdy, 1'b1);
      check("app select", sfa_flash_model_i.sel1, 1'b1);
      check("app data", sfa_flash_model_i.data, 32'h1234_5678);
   endtask
   task automatic t_concurrent;
      int n, f;
      logic [1:0] seen;
      shared <= 1'b1;
      f = sfa_flash_model_i.frames;
      seen = 2'b00;
      @(posedge clk);
      dir_addr <= {24'h000200, 24'h400300};
      dir_req <= 2'b11;
      for (n = 0; n < 4000 && seen != 2'b11; n++) begin
         @(posedge clk);
         for (int p = 0; p < 2; p++) begin
            if (dir_rdy[p] === 1'b1) begin
               seen[p] = 1'b1;
               dir_req[p] <= 1'b0;
               check("shared fetch", dir_rd[p], p ? 32'h5a00_0200 : 32'h5a40_0300);
            end
         end
      end
      check("both served", seen, 2'b11);
      check("frames on link", sfa_flash_model_i.frames - f, 2);
   endtask
   initial begin
      {clk, shared, hwc, wp, mode3, dir_req, dec_en, ind_req, width, ind_op} = '0;
      rst = 1'b1;
      {split, limit, dir_addr, ind_addr, key, ind_wd} = '0;
      errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_widths;
      t_decrypt;
      t_shared_app;
      t_net_ops;
      t_protect;
      t_separate_app;
      t_concurrent;
      final_report;
   end
endmodule
`default_nettype wire
